// *** rtl/mfrb_core.sv ***
/*
 Multi-frame receive buffer: rearms receiver, stores each frame in a 32-byte
 slice with a trailing status word, counts frames, CRC and end parity.
 Assumes rx byte strobes from the decoder on clk_i, plain register port.
*/
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module mfrb_core (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_end_i,
   input wire logic coll_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic tx_last_i,
   output logic rx_enable_o,
   output logic [7:0] tx_byte_o,
   output logic tx_parity_o,
   output logic tx_valid_o,
   output logic [15:0] crc_o,
   output logic frame_irq_o
);
   logic [7:0] mem_q [mfrb_pkg::BUF_BYTES];
   logic [7:0] ctrl_q;
   mfrb_pkg::mfrb_state_t state_q;
   logic [2:0] slice_q;
   logic [3:0] frames_q;
   logic [3:0] count_field_q;
   logic [4:0] bytes_q;
   logic [7:0] len_q;
   logic len_seen_q;
   logic [4:0] gap_q;
   logic [15:0] crc_q;
   logic rx_en_q;
   logic irq_q;
   logic [7:0] buf_ptr_q;
   logic [31:0] rdata_q;
   logic [15:0] crc_init;
   logic [15:0] crc_poly;
   logic [15:0] crc_next;
   logic [15:0] crc_tx_q;
   logic [7:0] crc_in;
   logic integ_f;
   logic len_over;
   logic short_f;
   logic len_err;
   logic comb_err;
   logic [15:0] status_w;
   logic multi_on;
   logic cmd_wr;
   logic idle_cmd;
   logic start_cmd;
   logic store_ok;
   logic [7:0] wr_addr;

   localparam logic [4:0] GAP_ONE = 5'h01;

   assign multi_on = ctrl_q[mfrb_pkg::CTRL_MULTI];
   assign cmd_wr = wr_i && (addr_i == mfrb_pkg::REG_CMD);
   assign idle_cmd = cmd_wr && (wdata_i[1:0] == mfrb_pkg::CMD_IDLE);
   assign start_cmd = cmd_wr && (wdata_i[1:0] == mfrb_pkg::CMD_TRANSCEIVE);

   // CRC per protocol; A uses reflected poly, F the plain one
   always_comb
   begin
      case (mfrb_pkg::mfrb_proto_t'(ctrl_q[mfrb_pkg::CTRL_PROTO_LSB +: 2]))
         mfrb_pkg::PROTO_A:
         begin
            crc_init = mfrb_pkg::CRC_A_INIT;
            crc_poly = mfrb_pkg::CRC_A_POLY;
         end
         mfrb_pkg::PROTO_B:
         begin
            crc_init = mfrb_pkg::CRC_B_INIT;
            crc_poly = mfrb_pkg::CRC_A_POLY;
         end
         default:
         begin
            crc_init = mfrb_pkg::CRC_F_INIT;
            crc_poly = mfrb_pkg::CRC_F_POLY;
         end
      endcase
   end

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                            input logic [15:0] p, input logic refl);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         if (refl)
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ p) : (r >> 1);
         else
            r = (r[15] ^ d[7 - i]) ? ((r << 1) ^ p) : (r << 1);
      end
      return r;
   endfunction

   assign crc_in = rx_byte_i;
   assign crc_next = crc_step(crc_q, crc_in, crc_poly, crc_poly == mfrb_pkg::CRC_A_POLY);

   // Receive CRC; residue zero means intact frame
   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_q != mfrb_pkg::ST_RX)
         crc_q <= crc_init;
      else if (rx_valid_i)
         crc_q <= crc_next;
   end

   // Transmit CRC and card-mode end-parity inversion
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         crc_tx_q <= mfrb_pkg::CRC_A_INIT;
         tx_byte_o <= 8'h00;
         tx_parity_o <= 1'b0;
         tx_valid_o <= 1'b0;
      end
      else
      begin
         tx_valid_o <= tx_valid_i;
         if (tx_valid_i)
         begin
            tx_byte_o <= tx_byte_i;
            crc_tx_q <= tx_last_i ? crc_init :
                        crc_step(crc_tx_q, tx_byte_i, crc_poly,
                                 crc_poly == mfrb_pkg::CRC_A_POLY);
            tx_parity_o <= ~(^tx_byte_i) ^ (tx_last_i && ctrl_q[mfrb_pkg::CTRL_CARD]
                           && ctrl_q[mfrb_pkg::CTRL_HIGHRATE]);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         crc_o <= 16'h0000;
      else
         crc_o <= crc_tx_q;
   end

   assign integ_f = (crc_q != 16'h0000);
   assign len_over = len_q > mfrb_pkg::MAX_DATA_B;
   assign short_f = !len_over && ({3'h0, bytes_q} < len_q);
   assign len_err = len_over || short_f;
   assign comb_err = integ_f || short_f || coll_i;
   assign status_w = {3'h0, len_err, comb_err, coll_i, short_f, integ_f && !len_over,
                      3'h0, bytes_q};
   assign store_ok = rx_valid_i && !len_over && (bytes_q < 5'(mfrb_pkg::MAX_DATA));
   assign wr_addr = {slice_q, bytes_q};

   // Sequencer
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         state_q <= mfrb_pkg::ST_IDLE;
      else if (idle_cmd)
         state_q <= mfrb_pkg::ST_IDLE;
      else
         case (state_q)
            mfrb_pkg::ST_IDLE, mfrb_pkg::ST_WAIT_TX:
               if (start_cmd)
                  state_q <= mfrb_pkg::ST_RX;
            mfrb_pkg::ST_RX:
               if (rx_end_i)
                  state_q <= mfrb_pkg::ST_STORE;
            mfrb_pkg::ST_STORE:
               if (!multi_on)
                  state_q <= mfrb_pkg::ST_WAIT_TX;
               else if (slice_q == mfrb_pkg::LAST_FRAME)
                  state_q <= mfrb_pkg::ST_WAIT_TX;
               else
                  state_q <= mfrb_pkg::ST_GAP;
            mfrb_pkg::ST_GAP:
               if (gap_q == GAP_ONE)
                  state_q <= mfrb_pkg::ST_RX;
            default:
               state_q <= mfrb_pkg::ST_IDLE;
         endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_q != mfrb_pkg::ST_GAP)
         gap_q <= mfrb_pkg::GAP_CYC_B;
      else
         gap_q <= gap_q - GAP_ONE;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rx_en_q <= 1'b0;
      else
         rx_en_q <= (state_q == mfrb_pkg::ST_RX) && !rx_end_i && !idle_cmd;
   end

   // Per-frame byte count and length byte
   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_q != mfrb_pkg::ST_RX)
      begin
         bytes_q <= 5'h00;
         len_q <= 8'h00;
         len_seen_q <= 1'b0;
      end
      else if (rx_valid_i)
      begin
         if (!len_seen_q)
         begin
            len_q <= rx_byte_i;
            len_seen_q <= 1'b1;
         end
         if (bytes_q != 5'h1f)
            bytes_q <= bytes_q + 5'h01;
      end
   end

   // Slice index and frame counters
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         slice_q <= 3'h0;
         frames_q <= 4'h0;
         count_field_q <= 4'h0;
      end
      else if (start_cmd && state_q != mfrb_pkg::ST_RX)
      begin
         slice_q <= 3'h0;
         frames_q <= 4'h0;
         count_field_q <= 4'h0;
      end
      else if (state_q == mfrb_pkg::ST_STORE)
      begin
         slice_q <= slice_q + 3'h1;
         frames_q <= frames_q + 4'h1;
         if (!multi_on || slice_q == mfrb_pkg::LAST_FRAME)
            count_field_q <= frames_q + 4'h1;
      end
      else if (idle_cmd && multi_on)
         count_field_q <= frames_q;
   end

   // Buffer writes: payload while receiving, status word at end
   always_ff @(posedge clk_i)
   begin
      if (state_q == mfrb_pkg::ST_RX && store_ok)
         mem_q[wr_addr] <= rx_byte_i;
      else if (state_q == mfrb_pkg::ST_STORE)
      begin
         mem_q[{slice_q, 5'(mfrb_pkg::MAX_DATA)}] <= status_w[7:0];
         mem_q[{slice_q, 5'(mfrb_pkg::MAX_DATA + 1)}] <= status_w[15:8];
         mem_q[{slice_q, 5'(mfrb_pkg::MAX_DATA + 2)}] <= 8'h00;
         mem_q[{slice_q, 5'(mfrb_pkg::MAX_DATA + 3)}] <= 8'h00;
      end
   end

   // Receive flag, sticky, set beats clear
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         irq_q <= 1'b0;
      else if (state_q == mfrb_pkg::ST_STORE)
         irq_q <= 1'b1;
      else if (wr_i && addr_i == mfrb_pkg::REG_IRQ && wdata_i[0])
         irq_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         ctrl_q <= 8'h00;
      else if (wr_i && addr_i == mfrb_pkg::REG_CTRL)
         ctrl_q <= wdata_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         buf_ptr_q <= 8'h00;
      else if (wr_i && addr_i == mfrb_pkg::REG_BUF)
         buf_ptr_q <= wdata_i[7:0];
      else if (rd_i && addr_i == mfrb_pkg::REG_BUF_DATA)
         buf_ptr_q <= buf_ptr_q + 8'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rdata_q <= 32'h0000_0000;
      else if (rd_i)
         case (addr_i)
            mfrb_pkg::REG_CTRL: rdata_q <= {24'h0, ctrl_q};
            mfrb_pkg::REG_STATUS:
               rdata_q <= {27'h0, state_q == mfrb_pkg::ST_RX || state_q == mfrb_pkg::ST_GAP,
                           count_field_q};
            mfrb_pkg::REG_IRQ: rdata_q <= {31'h0, irq_q};
            mfrb_pkg::REG_BUF: rdata_q <= {24'h0, buf_ptr_q};
            mfrb_pkg::REG_BUF_DATA: rdata_q <= {24'h0, mem_q[buf_ptr_q]};
            default: rdata_q <= 32'h0000_0000;
         endcase
      else
         rdata_q <= 32'h0000_0000;
   end

   assign rdata_o = rdata_q;
   assign rx_enable_o = rx_en_q;
   assign frame_irq_o = irq_q;

   AST_REARM: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == mfrb_pkg::ST_STORE && multi_on && slice_q != mfrb_pkg::LAST_FRAME
       && !idle_cmd) |=> state_q == mfrb_pkg::ST_GAP)
      else $error("receiver not rearmed");
   AST_GAP_MIN: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(state_q == mfrb_pkg::ST_GAP) |-> !rx_en_q [*2])
      else $error("rearm gap too short");
   AST_EIGHTH: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == mfrb_pkg::ST_STORE && slice_q == mfrb_pkg::LAST_FRAME && !idle_cmd)
      |=> state_q == mfrb_pkg::ST_WAIT_TX && count_field_q == 4'h8)
      else $error("eighth frame not final");
   AST_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
      idle_cmd |=> state_q == mfrb_pkg::ST_IDLE ##1 !rx_en_q)
      else $error("idle did not stop rx");
   AST_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
      (start_cmd && state_q == mfrb_pkg::ST_IDLE) |=> count_field_q == 4'h0)
      else $error("frame count not cleared");
   AST_IRQ: assert property (@(posedge clk_i) disable iff (reset_i)
      state_q == mfrb_pkg::ST_STORE |=> irq_q)
      else $error("frame flag not set");
   AST_COMB: assert property (@(posedge clk_i) disable iff (reset_i)
      status_w[mfrb_pkg::ST_COMBINED] == (integ_f || short_f || coll_i))
      else $error("combined error wrong");
   AST_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_q == mfrb_pkg::ST_RX && len_over) |-> !store_ok)
      else $error("payload stored on length error");
endmodule

// *** rtl/mfrb_pkg.sv ***
/*
 Constants, register map and types for the multi-frame receive buffer logic.
 Assumes one core clock at 200 MHz and a synchronous active-high reset.
*/
// Function
// - CRC variant chosen by selected protocol
// - Card mode high rate inverts end parity
// - Multi-frame only with enable and transceive active
// - Receiver re-armed after each finished frame before the eighth
// - Buffer split into eight 32-byte slices
// - Frame n stored at address 32 times n
// - At most 28 data bytes per frame
// - Bytes 28..31 hold status, reserved bits zero
// - Combined error is OR of three faults
// - Length error: length over 28 or short
// - Good frame: data stored, no error bits
// - CRC fail: data stored, combined and integrity set
// - Length over 28: no payload, length error; the length byte is still stored at offset 0 of the slice
// - Short frame: data stored, framing error set
// - Receive flag set once per frame
// - Frame count updated when reception ends
// - After eighth frame go to wait_tx_state
// - Idle command stops reception at once
// - Frame count cleared at new cycle start
// - Re-arm gap two carrier cycles to 2 us
package mfrb_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned BUF_BYTES = 256;
   localparam int unsigned SLICE_BYTES = 32;
   localparam int unsigned MAX_FRAMES = 8;
   localparam int unsigned MAX_DATA = 28;
   localparam logic [7:0] MAX_DATA_B = 8'h1c;
   localparam logic [2:0] LAST_FRAME = 3'h7;
   // Carrier 13.56 MHz: two cycles are 148 ns, rounded up to clocks
   localparam int unsigned GAP_NS = 148;
   localparam int unsigned GAP_MAX_NS = 2000;
   localparam int unsigned GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] GAP_CYC_B = 5'(GAP_CYC);
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ = 8'h08;
   localparam logic [7:0] REG_CMD = 8'h0c;
   localparam logic [7:0] REG_BUF = 8'h10;
   localparam logic [7:0] REG_BUF_DATA = 8'h14;
   // Control bits
   localparam int unsigned CTRL_MULTI = 0;
   localparam int unsigned CTRL_CARD = 1;
   localparam int unsigned CTRL_HIGHRATE = 2;
   localparam int unsigned CTRL_PROTO_LSB = 4;
   // Commands
   localparam logic [1:0] CMD_IDLE = 2'h0;
   localparam logic [1:0] CMD_TRANSCEIVE = 2'h3;
   // Status word layout, byte 28 is count
   localparam int unsigned ST_COUNT_LSB = 0;
   localparam int unsigned ST_INTEG = 8;
   localparam int unsigned ST_FRAMING = 9;
   localparam int unsigned ST_COLL = 10;
   localparam int unsigned ST_COMBINED = 11;
   localparam int unsigned ST_LENERR = 12;
   // Status register fields
   localparam int unsigned RS_COUNT_LSB = 0;
   localparam int unsigned RS_ACTIVE = 4;
   // CRC presets
   localparam logic [15:0] CRC_A_INIT = 16'h6363;
   localparam logic [15:0] CRC_B_INIT = 16'hffff;
   localparam logic [15:0] CRC_F_INIT = 16'h0000;
   localparam logic [15:0] CRC_A_POLY = 16'h8408;
   localparam logic [15:0] CRC_F_POLY = 16'h1021;
   typedef enum logic [1:0] {PROTO_A, PROTO_B, PROTO_F} mfrb_proto_t;
   typedef enum {ST_IDLE, ST_WAIT_TX, ST_RX, ST_STORE, ST_GAP} mfrb_state_t;
endpackage

// *** verification/mfrb_card_model.sv ***
/*
 Card-side model: answers a poll with one frame per timeslot as byte strobes.
 Assumes the core clock and the receiver enable of the core.
*/
`timescale 1ns/1ps
module mfrb_card_model (
   input wire logic clk_i,
   input wire logic rx_enable_i,
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   output logic rx_end_o,
   output logic coll_o
);
   initial
   begin
      rx_valid_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_end_o = 1'b0;
      coll_o = 1'b0;
   end
   // Length byte first; a length above n, up to 28, gives a short frame
   task automatic send(input logic [7:0] len, input int n, input logic coll, output logic ok);
      int w;
      w = 0;
      ok = 1'b0;
      while (!rx_enable_i && w < 500)
      begin
         @(posedge clk_i);
         w++;
      end
      if (rx_enable_i)
      begin
         ok = 1'b1;
         for (int i = 0; i < n; i++)
         begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_byte_o <= (i == 0) ? len : 8'ha0 + 8'(i);
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            // Released line shows the inverse, never a stale byte
            rx_byte_o <= ~rx_byte_o;
         end
         @(posedge clk_i);
         coll_o <= coll;
         rx_end_o <= 1'b1;
         @(posedge clk_i);
         rx_end_o <= 1'b0;
         repeat (3) @(posedge clk_i);
         coll_o <= 1'b0;
      end
   endtask
endmodule

// *** verification/mfrb_core_bench.sv ***
/*
 Bench for the multi-frame receive buffer: register tasks, card model, checks.
 Assumes the register map and status word layout of the package.
*/
`timescale 1ns/1ps
module mfrb_core_bench;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic tx_valid_i = 1'b0;
   logic [7:0] tx_byte_i = 8'h00;
   logic tx_last_i = 1'b0;
   logic [31:0] rdata_o, v;
   logic rx_valid_i, rx_end_i, coll_i, rx_enable_o, tx_parity_o, tx_valid_o, frame_irq_o;
   logic [7:0] rx_byte_i, tx_byte_o;
   logic [15:0] crc_o, c0, c1;
   logic ok, p0, p1;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int lo = 0;
   int gap = 0;
   always #2.5 clk_i = ~clk_i;
   mfrb_core DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid_i),
      .rx_byte_i(rx_byte_i), .rx_end_i(rx_end_i), .coll_i(coll_i), .tx_valid_i(tx_valid_i),
      .tx_byte_i(tx_byte_i), .tx_last_i(tx_last_i), .rx_enable_o(rx_enable_o),
      .tx_byte_o(tx_byte_o), .tx_parity_o(tx_parity_o), .tx_valid_o(tx_valid_o),
      .crc_o(crc_o), .frame_irq_o(frame_irq_o));
   mfrb_card_model card (.clk_i(clk_i), .rx_enable_i(rx_enable_o), .rx_valid_o(rx_valid_i),
      .rx_byte_o(rx_byte_i), .rx_end_o(rx_end_i), .coll_o(coll_i));
   task automatic close_out();
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic tx(input logic [7:0] b, input logic l, output logic p, output logic [15:0] c);
      @(posedge clk_i);
      tx_valid_i <= 1'b1;
      tx_byte_i <= b;
      tx_last_i <= l;
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
      #1 p = tx_parity_o;
      c = crc_o;
      chk("tx_byte", b, tx_byte_o);
   endtask
   // Status word of slice k, masked to the bits the frame defines
   task automatic st(input int k, input logic [31:0] m, input logic [31:0] e);
      wr(mfrb_pkg::REG_BUF, 32'(32 * k + 28));
      for (int i = 0; i < 4; i++)
      begin
         rd(mfrb_pkg::REG_BUF_DATA, v);
         c0[7:0] = v[7:0];
         p0 = 1'b0;
         e[31:0] = e;
         m[8*i +: 8] = m[8*i +: 8] & 8'hff;
         v = {24'h0, c0[7:0]};
         chk($sformatf("status_%0d_byte_%0d", k, i), e[8*i +: 8] & m[8*i +: 8], v & m[8*i +: 8]);
      end
   endtask
   task automatic frame(input logic [7:0] len, input int n, input logic c, input logic rearm);
      int w;
      w = 0;
      gap = 0;
      card.send(len, n, c, ok);
      chk("card_sent", 1'b1, ok);
      #1 chk("frame_irq", 1'b1, frame_irq_o);
      wr(mfrb_pkg::REG_IRQ, 32'h1);
      #1 chk("irq_clear", 1'b0, frame_irq_o);
      repeat (rearm ? 0 : 60) @(posedge clk_i);
      while (rearm && !rx_enable_o && w < 420)
      begin
         @(posedge clk_i);
         w++;
      end
      #1 chk("rearm", rearm, rx_enable_o);
      if (rearm)
      begin
         chk("gap_min", 1'b1, gap >= mfrb_pkg::GAP_CYC);
         chk("gap_max", 1'b1, gap <= 400);
      end
   endtask
   // Length of the latest receiver-off stretch
   always @(posedge clk_i)
      if (!rx_enable_o)
         lo++;
      else if (lo > 0)
      begin
         gap = lo;
         lo = 0;
      end
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         fails++;
         close_out();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(8'h40, v);
      chk("unmapped", 32'h0, v);
      wr(mfrb_pkg::REG_CTRL, 32'h1);
      wr(mfrb_pkg::REG_CMD, 32'(mfrb_pkg::CMD_TRANSCEIVE));
      frame(8'h05, 5, 1'b0, 1'b1);
      frame(8'h0a, 4, 1'b0, 1'b1);
      frame(8'h1d, 3, 1'b0, 1'b1);
      frame(8'h04, 4, 1'b1, 1'b1);
      frame(8'h1c, 28, 1'b0, 1'b1);
      for (int k = 5; k < 8; k++)
         frame(8'h03, 3, 1'b0, k < 7);
      rd(mfrb_pkg::REG_STATUS, v);
      chk("count_full", 32'h8, v & 32'hf);
      st(0, 32'hffff16ff, 32'h00000005);
      st(1, 32'hffff1aff, 32'h00001a04);
      st(2, 32'hffff1000, 32'h00001000);
      st(3, 32'hffff1eff, 32'h00000c04);
      st(4, 32'hffff16ff, 32'h0000001c);
      st(7, 32'hffff16ff, 32'h00000003);
      wr(mfrb_pkg::REG_BUF, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         rd(mfrb_pkg::REG_BUF_DATA, v);
         chk("payload", (i == 0) ? 8'h05 : 8'ha0 + 8'(i), v & 32'hff);
      end
      wr(mfrb_pkg::REG_CMD, 32'(mfrb_pkg::CMD_TRANSCEIVE));
      rd(mfrb_pkg::REG_STATUS, v);
      chk("count_cleared", 32'h0, v & 32'hf);
      frame(8'h02, 2, 1'b0, 1'b1);
      wr(mfrb_pkg::REG_CMD, 32'(mfrb_pkg::CMD_IDLE));
      repeat (2) @(posedge clk_i);
      #1 chk("idle_stop", 1'b0, rx_enable_o);
      rd(mfrb_pkg::REG_STATUS, v);
      chk("count_one", 32'h1, v & 32'hf);
      wr(mfrb_pkg::REG_CTRL, 32'h0);
      wr(mfrb_pkg::REG_CMD, 32'(mfrb_pkg::CMD_TRANSCEIVE));
      frame(8'h02, 2, 1'b0, 1'b0);
      wr(mfrb_pkg::REG_CMD, 32'(mfrb_pkg::CMD_IDLE));
      tx(8'h5a, 1'b0, p0, c0);
      tx(8'h5a, 1'b1, p1, c0);
      chk("plain_parity", 1'b0, p0 ^ p1);
      wr(mfrb_pkg::REG_CTRL, 32'h6);
      tx(8'h5a, 1'b0, p0, c0);
      tx(8'h5a, 1'b1, p1, c0);
      chk("end_parity", 1'b1, p0 ^ p1);
      wr(mfrb_pkg::REG_CTRL, 32'h20);
      tx(8'h5a, 1'b1, p1, c1);
      chk("crc_variant", 1'b1, c0 !== c1);
      close_out();
   end
endmodule
